//--- common/mdf_pkg.sv
// Purpose: shared constants for the measurement dump formatter
// Assumes: single 10 MHz instrument clock
// Notes: mode codes follow the dump command numbers 0..9
package mdf_pkg;
    localparam logic [3:0] MODE_FULL_COND = 4'h0;
    localparam logic [3:0] MODE_MKR_AMP = 4'h1;
    localparam logic [3:0] MODE_MKR_AMP_FREQ = 4'h2;
    localparam logic [3:0] MODE_TRACE_A = 4'h3;
    localparam logic [3:0] MODE_TRACE_B = 4'h4;
    localparam logic [3:0] MODE_CAL = 4'h5;
    localparam logic [3:0] MODE_SHORT_COND = 4'h6;
    localparam logic [3:0] MODE_DISP_TEXT = 4'h7;
    localparam logic [3:0] MODE_AMP_RETRIG = 4'h8;
    localparam logic [3:0] MODE_AMP_FREQ_RETRIG = 4'h9;
    localparam logic [3:0] MODE_RESET = MODE_MKR_AMP;
    // special trigger selection, zero means none active
    localparam logic [1:0] TRIG_NONE = 2'h0;
    localparam logic [1:0] TRIG_LAST = 2'h3;
    // data source selectors presented on src_sel
    localparam logic [2:0] SRC_MKR_AMP = 3'h0;
    localparam logic [2:0] SRC_MKR_FREQ = 3'h1;
    localparam logic [2:0] SRC_TRACE_A = 3'h2;
    localparam logic [2:0] SRC_TRACE_B = 3'h3;
    localparam logic [2:0] SRC_CAL_FREQ = 3'h4;
    localparam logic [2:0] SRC_CAL_AMP = 3'h5;
    localparam logic [2:0] SRC_DISP = 3'h6;
    // record geometry
    localparam logic [9:0] TRACE_POINTS = 10'd1001;
    localparam logic [9:0] CAL_PAIRS = 10'd9;
    localparam logic [9:0] DISP_FIELDS = 10'd10;
    localparam logic [9:0] ONE_ITEM = 10'd1;
    localparam logic [3:0] AMP_LEN = 4'd11;
    localparam logic [3:0] FREQ_LEN = 4'd12;
    localparam logic [3:0] DISP_LEN = 4'd12;
    // highest char index that may be blanked as a leading zero, and last status byte index of each condition dump
    localparam logic [3:0] AMP_BLANK_LAST = 4'd4;
    localparam logic [3:0] FREQ_BLANK_LAST = 4'd8;
    localparam logic [1:0] FULL_COND_LAST = 2'd2;
    localparam logic [1:0] SHORT_COND_LAST = 2'd1;
    // ascii
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_ONE = 8'h31;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_DOT = 8'h2E;
    localparam logic [7:0] CH_NUL = 8'h00;
    localparam logic [5:0] ERR_MIN = 6'd1;
    localparam logic [5:0] ERR_MAX = 6'd36;
    typedef enum {PH_IDLE, PH_ADDR, PH_WAIT, PH_LOAD, PH_SEND} mdf_phase_t;
    typedef enum {K_STAT, K_CHAR, K_COMMA, K_CR, K_LF} mdf_kind_t;
endpackage

//--- hw/mdf_formatter.sv
// Purpose: selects and formats dump output bytes for the instrument bus talker
// Assumes: all inputs come from same-clock logic (bus handshake and instrument state)
// Notes: source store answers src_sel/src_item/src_char with one cycle of latency
`timescale 1ns/10ps

module mdf_formatter (
    input wire logic clock,
    input wire logic rst,
    input wire logic preset,
    input wire logic dev_clear,
    input wire logic mode_wr,
    input wire logic [3:0] mode_sel,
    input wire logic trig_wr,
    input wire logic [1:0] trig_sel,
    input wire logic meas_trigger,
    input wire logic autorange_busy,
    input wire logic overload,
    input wire logic below_scale,
    input wire logic input_tripped,
    input wire logic sweep_uncal,
    input wire logic lo_unlocked,
    input wire logic sweeping,
    input wire logic error_shown,
    input wire logic [5:0] error_code,
    input wire logic cal_done,
    input wire logic cal_failed,
    input wire logic [7:0] cal_error_num,
    input wire logic [7:0] src_data,
    input wire logic out_ready,
    output logic [2:0] src_sel,
    output logic [9:0] src_item,
    output logic [3:0] src_char,
    output logic [7:0] out_data,
    output logic out_valid,
    output logic out_eoi,
    output logic retrig_pulse,
    output logic [1:0] retrig_kind
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [3:0] dump_mode;
    logic [1:0] special_trig;
    logic armed;
    logic lo_sticky;
    logic err_sticky;
    logic cal_err_sticky;
    logic [5:0] err_byte;
    logic [7:0] cal_err_byte;
    logic [7:0] extended_condition_byte;
    mdf_pkg::mdf_phase_t phase;
    mdf_pkg::mdf_kind_t kind;
    logic [9:0] item_cnt;
    logic part;
    logic [3:0] char_cnt;
    logic [1:0] byte_idx;
    logic leading;
    logic clr;
    logic retrig_mode;
    logic stat_mode;
    logic [9:0] n_items;
    logic two_parts;
    logic [2:0] cur_src;
    logic [3:0] cur_len;
    logic [3:0] blank_last;
    logic [1:0] stat_last;
    logic last_part;
    logic accept;
    logic [7:0] next_char;

    assign clr = preset | dev_clear;
    assign accept = out_valid & out_ready;
    assign retrig_mode = (dump_mode == mdf_pkg::MODE_AMP_RETRIG)
                       | (dump_mode == mdf_pkg::MODE_AMP_FREQ_RETRIG);
    assign stat_mode = (dump_mode == mdf_pkg::MODE_FULL_COND)
                     | (dump_mode == mdf_pkg::MODE_SHORT_COND);
    assign stat_last = (dump_mode == mdf_pkg::MODE_SHORT_COND) ?
                       mdf_pkg::SHORT_COND_LAST : mdf_pkg::FULL_COND_LAST;
    assign last_part = (part | ~two_parts) & (item_cnt == n_items - mdf_pkg::ONE_ITEM);

    ////////////////////////////////////////////////////////////////////////////////
    // record shape per mode
    always_comb
    begin
        n_items = mdf_pkg::ONE_ITEM;
        two_parts = 1'b0;
        cur_src = mdf_pkg::SRC_MKR_AMP;
        unique case (dump_mode)
            mdf_pkg::MODE_MKR_AMP_FREQ, mdf_pkg::MODE_AMP_FREQ_RETRIG:
            begin
                two_parts = 1'b1;
                cur_src = part ? mdf_pkg::SRC_MKR_AMP : mdf_pkg::SRC_MKR_FREQ;
            end
            mdf_pkg::MODE_TRACE_A:
            begin
                n_items = mdf_pkg::TRACE_POINTS;
                cur_src = mdf_pkg::SRC_TRACE_A;
            end
            mdf_pkg::MODE_TRACE_B:
            begin
                n_items = mdf_pkg::TRACE_POINTS;
                cur_src = mdf_pkg::SRC_TRACE_B;
            end
            mdf_pkg::MODE_CAL:
            begin
                n_items = mdf_pkg::CAL_PAIRS;
                two_parts = 1'b1;
                cur_src = part ? mdf_pkg::SRC_CAL_AMP : mdf_pkg::SRC_CAL_FREQ;
            end
            mdf_pkg::MODE_DISP_TEXT:
            begin
                n_items = mdf_pkg::DISP_FIELDS;
                cur_src = mdf_pkg::SRC_DISP;
            end
            default:
            begin
                n_items = mdf_pkg::ONE_ITEM;
            end
        endcase
    end

    always_comb
    begin
        cur_len = mdf_pkg::AMP_LEN;
        blank_last = mdf_pkg::AMP_BLANK_LAST;
        if (cur_src == mdf_pkg::SRC_MKR_FREQ || cur_src == mdf_pkg::SRC_CAL_FREQ)
        begin
            cur_len = mdf_pkg::FREQ_LEN;
            blank_last = mdf_pkg::FREQ_BLANK_LAST;
        end
        else if (cur_src == mdf_pkg::SRC_DISP)
        begin
            cur_len = mdf_pkg::DISP_LEN;
            blank_last = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // single mode, single trigger
    always_ff @(posedge clock)
    begin
        if (rst || preset)
        begin
            dump_mode <= mdf_pkg::MODE_RESET;
            special_trig <= mdf_pkg::TRIG_NONE;
        end
        else
        begin
            if (mode_wr && mode_sel <= mdf_pkg::MODE_AMP_FREQ_RETRIG)
                dump_mode <= mode_sel;
            if (trig_wr)
                special_trig <= trig_sel;
        end
    end

    // sticky bits, a new event wins over clear
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            lo_sticky <= 1'b0;
            err_sticky <= 1'b0;
            cal_err_sticky <= 1'b0;
        end
        else
        begin
            lo_sticky <= lo_unlocked | (lo_sticky & ~clr);
            err_sticky <= error_shown | (err_sticky & ~clr);
            if (cal_done)
                cal_err_sticky <= cal_failed;
            else if (clr)
                cal_err_sticky <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            err_byte <= '0;
        else if (error_shown && error_code >= mdf_pkg::ERR_MIN
                 && error_code <= mdf_pkg::ERR_MAX)
            err_byte <= error_code;
        else if (clr)
            err_byte <= '0;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            cal_err_byte <= '0;
        else if (cal_done)
            cal_err_byte <= cal_error_num;
    end

    // only the dump path reads this byte
    always_comb
    begin
        extended_condition_byte[0] = autorange_busy | overload;
        extended_condition_byte[1] = autorange_busy | below_scale;
        extended_condition_byte[2] = input_tripped;
        extended_condition_byte[3] = sweep_uncal;
        extended_condition_byte[4] = lo_sticky;
        extended_condition_byte[5] = err_sticky;
        extended_condition_byte[6] = cal_err_sticky;
        extended_condition_byte[7] = sweeping;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // trigger arms the next dump
    always_ff @(posedge clock)
    begin
        if (rst || clr || mode_wr)
            armed <= 1'b0;
        else if (meas_trigger)
            armed <= 1'b1;
        else if (phase == mdf_pkg::PH_IDLE && !retrig_mode)
            armed <= 1'b0;
    end

    // source address follows the counters; one cycle early of the sample
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            src_sel <= mdf_pkg::SRC_MKR_AMP;
            src_item <= '0;
            src_char <= '0;
        end
        else
        begin
            src_sel <= cur_src;
            src_item <= item_cnt;
            src_char <= char_cnt;
        end
    end

    // character shaping
    always_comb
    begin
        next_char = src_data;
        if (cur_src == mdf_pkg::SRC_DISP)
        begin
            if (src_data == mdf_pkg::CH_NUL)
                next_char = mdf_pkg::CH_SPACE;
        end
        else if (leading && src_data == mdf_pkg::CH_ZERO && char_cnt <= blank_last)
            next_char = mdf_pkg::CH_SPACE;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // byte sequencer
    always_ff @(posedge clock)
    begin
        if (rst || clr || mode_wr)
        begin
            phase <= mdf_pkg::PH_IDLE;
            kind <= mdf_pkg::K_STAT;
            item_cnt <= '0;
            part <= 1'b0;
            char_cnt <= '0;
            byte_idx <= '0;
            leading <= 1'b1;
            out_valid <= 1'b0;
            out_eoi <= 1'b0;
            out_data <= '0;
            retrig_pulse <= 1'b0;
            retrig_kind <= mdf_pkg::TRIG_NONE;
        end
        else
        begin
            retrig_pulse <= 1'b0;
            unique case (phase)
                mdf_pkg::PH_IDLE:
                begin
                    item_cnt <= '0;
                    part <= 1'b0;
                    char_cnt <= '0;
                    byte_idx <= '0;
                    leading <= 1'b1;
                    kind <= stat_mode ? mdf_pkg::K_STAT : mdf_pkg::K_CHAR;
                    if (armed || retrig_mode)
                        phase <= mdf_pkg::PH_ADDR;
                end
                mdf_pkg::PH_ADDR:
                    phase <= mdf_pkg::PH_WAIT;
                mdf_pkg::PH_WAIT:
                    phase <= mdf_pkg::PH_LOAD;
                mdf_pkg::PH_LOAD:
                begin
                    phase <= mdf_pkg::PH_SEND;
                    out_valid <= 1'b1;
                    out_eoi <= 1'b0;
                    unique case (kind)
                        mdf_pkg::K_STAT:
                        begin
                            out_eoi <= (byte_idx == stat_last);
                            if (byte_idx == 2'd0)
                                out_data <= extended_condition_byte;
                            else if (byte_idx == 2'd1)
                                out_data <= {2'b00, err_byte};
                            else
                                out_data <= cal_err_byte;
                        end
                        mdf_pkg::K_CHAR:
                        begin
                            out_data <= next_char;
                            if ((src_data >= mdf_pkg::CH_ONE && src_data <= mdf_pkg::CH_NINE)
                                || src_data == mdf_pkg::CH_DOT)
                                leading <= 1'b0;
                        end
                        mdf_pkg::K_COMMA:
                            out_data <= mdf_pkg::CH_COMMA;
                        mdf_pkg::K_CR:
                            out_data <= mdf_pkg::CH_CR;
                        mdf_pkg::K_LF:
                        begin
                            out_data <= mdf_pkg::CH_LF;
                            out_eoi <= 1'b1;
                        end
                    endcase
                end
                mdf_pkg::PH_SEND:
                begin
                    if (out_ready)
                    begin
                        out_valid <= 1'b0;
                        out_eoi <= 1'b0;
                        phase <= out_eoi ? mdf_pkg::PH_IDLE : mdf_pkg::PH_ADDR;
                        if (out_eoi && retrig_mode)
                        begin
                            retrig_pulse <= 1'b1;
                            retrig_kind <= special_trig;
                        end
                        unique case (kind)
                            mdf_pkg::K_STAT:
                                byte_idx <= byte_idx + 2'd1;
                            mdf_pkg::K_CHAR:
                            begin
                                if (char_cnt == cur_len - 4'd1)
                                begin
                                    char_cnt <= '0;
                                    kind <= last_part ? mdf_pkg::K_CR : mdf_pkg::K_COMMA;
                                end
                                else
                                    char_cnt <= char_cnt + 4'd1;
                            end
                            mdf_pkg::K_COMMA:
                            begin
                                kind <= mdf_pkg::K_CHAR;
                                leading <= 1'b1;
                                if (two_parts && !part)
                                    part <= 1'b1;
                                else
                                begin
                                    part <= 1'b0;
                                    item_cnt <= item_cnt + 10'd1;
                                end
                            end
                            mdf_pkg::K_CR:
                                kind <= mdf_pkg::K_LF;
                            mdf_pkg::K_LF:
                                kind <= mdf_pkg::K_LF;
                        endcase
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    AST_EOI_FINAL: assert property (@(posedge clock) disable iff (rst)
        (out_valid && out_eoi && !stat_mode) |-> (out_data == mdf_pkg::CH_LF))
        else $error("eoi not on final line feed");
    AST_PRESET_MODE: assert property (@(posedge clock) disable iff (rst)
        $past(preset) |-> (dump_mode == mdf_pkg::MODE_MKR_AMP))
        else $error("preset did not select marker amplitude dump");
    AST_CR_THEN_LF: assert property (@(posedge clock) disable iff (rst || clr || mode_wr)
        (accept && out_data == mdf_pkg::CH_CR && !stat_mode)
        |-> ##4 (out_valid && out_eoi && out_data == mdf_pkg::CH_LF))
        else $error("line feed with eoi did not follow carriage return");
    AST_ERR_CLEARED: assert property (@(posedge clock) disable iff (rst)
        (dev_clear && !error_shown) |=> (err_byte == '0) && !err_sticky)
        else $error("device clear left error state set");
    AST_RETRIG_FIRES: assert property (@(posedge clock)
        disable iff (rst || clr || mode_wr)
        (accept && out_eoi && retrig_mode) |=> (retrig_pulse && retrig_kind == special_trig))
        else $error("retrigger mode did not fire trigger after read");
    AST_NO_SPACE_HOLE: assert property (@(posedge clock) disable iff (rst)
        (out_valid && dump_mode == mdf_pkg::MODE_DISP_TEXT) |-> (out_data != mdf_pkg::CH_NUL))
        else $error("unused display character not sent as space");
    AST_NEEDS_TRIGGER: assert property (@(posedge clock) disable iff (rst || mode_wr)
        (phase == mdf_pkg::PH_IDLE && !retrig_mode && !armed) |=> (phase == mdf_pkg::PH_IDLE))
        else $error("dump started without trigger");
    AST_SHORT_LEN: assert property (@(posedge clock) disable iff (rst)
        (out_valid && out_eoi && dump_mode == mdf_pkg::MODE_SHORT_COND)
        |-> (byte_idx == mdf_pkg::SHORT_COND_LAST))
        else $error("short status dump has wrong length");
    AST_SWEEP_BIT: assert property (@(posedge clock) disable iff (rst)
        (phase == mdf_pkg::PH_LOAD && kind == mdf_pkg::K_STAT && byte_idx == 2'd0)
        |=> (out_data[7] == $past(sweeping)))
        else $error("sweep bit does not follow sweeping");

endmodule

//--- dv/mdf_store_model.sv
// Purpose: value store for the marker, trace, cal and display values
// Assumes: the address is held until its data is taken
// Notes: digits depend on the selector, so the two traces differ
`timescale 1ns/10ps
module mdf_store_model (
    input wire logic clock,
    input wire logic [2:0] src_sel,
    input wire logic [9:0] src_item,
    input wire logic [3:0] src_char,
    input wire logic [3:0] zeros,
    output logic [7:0] src_data
);
    logic freq;
    assign freq = src_sel == 3'h1 || src_sel == 3'h4;
    ////////////////////////////////////////////////////////////////////////////
    // raw zeros are left in, so the formatter has to blank them itself
    always_ff @(posedge clock)
    begin
        if (src_sel == 3'h6)
            src_data <= (src_char < 4'hC - zeros) ? 8'h41 + 8'(src_char) : 8'h00;
        else if (src_char == 4'h0 && !freq)
            src_data <= 8'h2B;
        else if (src_char < zeros)
            src_data <= 8'h30;
        else
            src_data <= 8'h31 + 8'((src_item + src_char + src_sel) % 9);
    end
endmodule

//--- dv/measurement_dump_formatter_tb_top.sv
// Purpose: self-checking bench for the dump formatter
// Assumes: the store model answers one cycle after the address
// Notes: the trace B dump is cut short by a mode write, to keep the run short
`timescale 1ns/10ps
module measurement_dump_formatter_tb_top;
    logic clock = 1'b0, rst = 1'b1, preset = 1'b0, dev_clear = 1'b0, mode_wr = 1'b0;
    logic trig_wr = 1'b0, meas_trigger = 1'b0, autorange_busy = 1'b0, overload = 1'b0;
    logic below_scale = 1'b0, input_tripped = 1'b0, sweep_uncal = 1'b0, lo_unlocked = 1'b0;
    logic sweeping = 1'b0, error_shown = 1'b0, cal_done = 1'b0, cal_failed = 1'b0;
    logic out_ready = 1'b0, retrig_pulse, out_valid, out_eoi, stk = 1'b0;
    logic [3:0] mode_sel = 4'h0, src_char, zeros = 4'h0;
    logic [1:0] trig_sel = 2'h0, retrig_kind;
    logic [5:0] error_code = 6'h00;
    logic [7:0] cal_error_num = 8'h00, src_data, out_data;
    logic [2:0] src_sel;
    logic [9:0] src_item;
    logic [7:0] exp[$];
    int err_total = 0, checked = 0, n;
    int ml[6] = '{2, 5, 7, 0, 6, 3};
    mdf_formatter uut (.*);
    mdf_store_model model (.*);
    always #50 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] ech(input int s, input int i, input int k);
        logic f;
        f = s == 1 || s == 4;
        if (s == 6)
            return (k < 12 - zeros) ? 8'h41 + 8'(k) : 8'h20;
        if (k == 0 && !f)
            return 8'h2B;
        if (k < zeros)
            return (k <= (f ? 8 : 4)) ? 8'h20 : 8'h30;
        return 8'h31 + 8'((i + k + s) % 9);
    endfunction
    task automatic add(input int s, input int i, input int len);
        for (int k = 0; k < len; k++)
            exp.push_back(ech(s, i, k));
    endtask
    task automatic build(input int m);
        exp.delete();
        if (m == 0 || m == 6)
        begin
            exp.push_back({sweeping, cal_failed & stk, stk, stk, sweep_uncal, input_tripped,
                autorange_busy | below_scale, autorange_busy | overload});
            exp.push_back(stk ? {2'h0, error_code} : 8'h00);
            if (m == 0)
                exp.push_back(cal_error_num);
            return;
        end
        if (m == 1 || m == 8)
            add(0, 0, 11);
        if (m == 2 || m == 9)
        begin
            add(1, 0, 12);
            exp.push_back(8'h2C);
            add(0, 0, 11);
        end
        for (int i = 0; i < (m == 3 || m == 4 ? 1001 : m == 5 ? 9 : m == 7 ? 10 : 0); i++)
        begin
            if (i > 0)
                exp.push_back(8'h2C);
            if (m == 5)
            begin
                add(4, i, 12);
                exp.push_back(8'h2C);
            end
            add(m == 5 ? 5 : m == 7 ? 6 : m - 1, i, m == 7 ? 12 : 11);
        end
        exp.push_back(8'h0D);
        exp.push_back(8'h0A);
    endtask
    task automatic chk(input logic [7:0] e, input logic [7:0] s, input string nm);
        checked++;
        if (s !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic dump(input int m, input int lim);
        int k, w;
        build(m);
        k = 0;
        w = 0;
        while (k < lim && k < exp.size() && w < 2000)
        begin
            @(posedge clock);
            out_ready <= ($urandom % 4) != 0;
            if (out_valid === 1'b1 && out_ready === 1'b1)
            begin
                chk(exp[k], out_data, "out_data");
                chk({7'h0, k == exp.size() - 1}, {7'h0, out_eoi}, "out_eoi");
                k++;
                w = 0;
            end
            else
                w++;
        end
        chk(8'h01, {7'h0, w < 2000}, "byte wait");
    endtask
    task automatic go(input int m, input logic t);
        @(posedge clock);
        {autorange_busy, overload, below_scale, input_tripped, sweep_uncal, sweeping} <= 6'($urandom);
        zeros <= 4'($urandom % 11);
        mode_sel <= 4'(m);
        mode_wr <= m >= 0;
        @(posedge clock);
        mode_wr <= 1'b0;
        meas_trigger <= t;
        @(posedge clock);
        meas_trigger <= 1'b0;
    endtask
    task results;
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (90000) @(posedge clock);
        err_total++;
        results();
    end
    initial
    begin
        void'($urandom(32'h2C779312));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        go(-1, 1'b1);
        dump(1, 13);
        repeat (20) @(posedge clock);
        chk({7'h0, out_valid}, 8'h00, "idle out_valid");
        error_shown <= 1'b1;
        error_code <= 6'(1 + $urandom % 36);
        lo_unlocked <= 1'b1;
        cal_done <= 1'b1;
        cal_failed <= 1'($urandom);
        cal_error_num <= 8'($urandom);
        @(posedge clock);
        {error_shown, lo_unlocked, cal_done} <= 3'h0;
        stk = 1'b1;
        foreach (ml[j])
        begin
            go(ml[j], 1'b1);
            dump(ml[j], 20000);
        end
        go(4, 1'b1);
        dump(4, 40);
        go(1, 1'b0);
        repeat (10) @(posedge clock);
        chk({7'h0, out_valid}, 8'h00, "aborted out_valid");
        for (int m = 8; m <= 9; m++)
        begin
            trig_sel <= 2'(1 + $urandom % 3);
            trig_wr <= 1'b1;
            @(posedge clock);
            trig_wr <= 1'b0;
            go(m, 1'b0);
            dump(m, 30);
            n = 0;
            while (n < 10 && retrig_pulse !== 1'b1)
            begin
                @(posedge clock);
                n++;
            end
            chk({7'h0, retrig_pulse}, 8'h01, "retrig_pulse");
            chk({6'h0, retrig_kind}, {6'h0, trig_sel}, "retrig_kind");
            dump(m, 30);
        end
        dev_clear <= 1'b1;
        @(posedge clock);
        dev_clear <= 1'b0;
        stk = 1'b0;
        go(6, 1'b1);
        dump(6, 2);
        {error_shown, lo_unlocked} <= 2'h3;
        @(posedge clock);
        {error_shown, lo_unlocked} <= 2'h0;
        preset <= 1'b1;
        @(posedge clock);
        preset <= 1'b0;
        stk = 1'b0;
        go(-1, 1'b1);
        dump(1, 13);
        go(6, 1'b1);
        dump(6, 2);
        results();
    end
endmodule
